//--- verilog/bst_pkg.sv
package bst_pkg;
  localparam int INS_W = 3;
  localparam int ID_W = 32;
  localparam int CHAIN_W = 98;
  localparam int GP_N = 8;
  localparam int GP_CELLS = 16;
  localparam int DIR_CELL = 16;
  localparam int OTHER_LO = 17;
  localparam int OTHER_W = CHAIN_W - OTHER_LO;
  localparam int SYNC_W = 3 + GP_N + OTHER_W;
  localparam int SYNC_TCK = 0;
  localparam int SYNC_TMS = 1;
  localparam int SYNC_TDI = 2;
  localparam int SYNC_GP = 3;
  localparam int SYNC_OTHER = SYNC_GP + GP_N;

  localparam logic [INS_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [INS_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [INS_W-1:0] INS_IDCODE = 3'h6;
  localparam logic [INS_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [INS_W-1:0] INS_CAPTURE = 3'h4;

  // identity values are arbitrary
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [3:0] ID_REV = 4'h1;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, ID_PART, ID_MAKER, 1'b1};

  localparam logic [CHAIN_W-1:0] CHAIN_RESET = '0;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SHIFT_DR = 4'h4,
    ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6,
    ST_EXIT2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_INS = 4'h9,
    ST_CAP_INS = 4'ha,
    ST_SHIFT_INS = 4'hb,
    ST_EXIT1_INS = 4'hc,
    ST_PAUSE_INS = 4'hd,
    ST_EXIT2_INS = 4'he,
    ST_UPD_INS = 4'hf
  } bst_state_t;

  typedef enum logic [1:0] {
    SEL_CHAIN = 2'h0,
    SEL_ID = 2'h1,
    SEL_SKIP = 2'h2
  } bst_sel_t;
endpackage

//--- verilog/bst_tap_if.sv
`timescale 1ns/100ps
interface bst_tap_if;
  import bst_pkg::*;
  logic tck_rise;
  logic tms;
  bst_state_t state;
  modport fsm (input tck_rise, input tms, output state);
  modport core (output tck_rise, output tms, input state);
endinterface

//--- verilog/bst_tap_fsm.sv
`timescale 1ns/100ps
module bst_tap_fsm
(
  input wire logic ref_clk,
  input wire logic rst,
  bst_tap_if.fsm tap
);
  import bst_pkg::*;

  bst_state_t state_reg;
  bst_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (tap.tck_rise)
    begin
      unique case (state_reg)
        ST_RESET: state_next = tap.tms ? ST_RESET : ST_IDLE;
        ST_IDLE: state_next = tap.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: state_next = tap.tms ? ST_SEL_INS : ST_CAP_DR;
        ST_CAP_DR: state_next = tap.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: state_next = tap.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: state_next = tap.tms ? ST_UPD_DR : ST_PAUSE_DR;
        ST_PAUSE_DR: state_next = tap.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: state_next = tap.tms ? ST_UPD_DR : ST_SHIFT_DR;
        ST_UPD_DR: state_next = tap.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_INS: state_next = tap.tms ? ST_RESET : ST_CAP_INS;
        ST_CAP_INS: state_next = tap.tms ? ST_EXIT1_INS : ST_SHIFT_INS;
        ST_SHIFT_INS: state_next = tap.tms ? ST_EXIT1_INS : ST_SHIFT_INS;
        ST_EXIT1_INS: state_next = tap.tms ? ST_UPD_INS : ST_PAUSE_INS;
        ST_PAUSE_INS: state_next = tap.tms ? ST_EXIT2_INS : ST_PAUSE_INS;
        ST_EXIT2_INS: state_next = tap.tms ? ST_UPD_INS : ST_SHIFT_INS;
        ST_UPD_INS: state_next = tap.tms ? ST_SEL_DR : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end

  assign tap.state = state_reg;
endmodule

//--- verilog/bst_top.sv
`timescale 1ns/100ps
module bst_top
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [bst_pkg::GP_N-1:0] general_pins_i,
  output logic [bst_pkg::GP_N-1:0] general_pins_o,
  output logic [bst_pkg::GP_N-1:0] general_pins_oe,
  input wire logic [bst_pkg::GP_N-1:0] core_gp_drive,
  input wire logic [bst_pkg::GP_N-1:0] core_gp_enable,
  output logic [bst_pkg::GP_N-1:0] core_gp_sample,
  input wire logic [bst_pkg::OTHER_W-1:0] other_pins_i,
  output logic [bst_pkg::OTHER_W-1:0] other_pins_drive,
  output logic test_drive_active
);
  import bst_pkg::*;

  function automatic logic [GP_CELLS-1:0] gp_interleave(input logic [GP_N-1:0] drv, input logic [GP_N-1:0] smp);
    logic [GP_CELLS-1:0] r;
    r = '0;
    for (int i = 0; i < GP_N; i++)
    begin
      r[2*i] = drv[i];
      r[2*i+1] = smp[i];
    end
    return r;
  endfunction

  function automatic logic [GP_N-1:0] gp_drive_cells(input logic [CHAIN_W-1:0] c);
    logic [GP_N-1:0] r;
    r = '0;
    for (int i = 0; i < GP_N; i++)
      r[i] = c[2*i];
    return r;
  endfunction

  function automatic bst_sel_t decode_sel(input logic [INS_W-1:0] code);
    bst_sel_t s;
    s = SEL_SKIP;
    if (code == INS_EXTEST || code == INS_SAMPLE)
      s = SEL_CHAIN;
    else if (code == INS_IDCODE)
      s = SEL_ID;
    return s;
  endfunction

  // pin sampling: three stages, a change is taken once stages two and three agree
  logic [SYNC_W-1:0] s1_reg, s1_next;
  logic [SYNC_W-1:0] s2_reg, s2_next;
  logic [SYNC_W-1:0] s3_reg, s3_next;
  logic [SYNC_W-1:0] filt_reg, filt_next;
  logic tck_old_reg, tck_old_next;
  logic tck_rise, tck_fall;

  always_comb
  begin
    s1_next = {other_pins_i, general_pins_i, tdi, tms, tck};
    s2_next = s1_reg;
    s3_next = s2_reg;
    filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    tck_old_next = filt_reg[SYNC_TCK];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      tck_old_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      filt_reg <= filt_next;
      tck_old_reg <= tck_old_next;
    end
  end

  // every shift, tdo and chain latch change is paced by these test clock edges only; pin outputs follow ref_clk
  assign tck_rise = filt_reg[SYNC_TCK] & ~tck_old_reg;
  assign tck_fall = ~filt_reg[SYNC_TCK] & tck_old_reg;

  bst_tap_if tap ();
  assign tap.tck_rise = tck_rise;
  assign tap.tms = filt_reg[SYNC_TMS];

  bst_tap_fsm u_fsm
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .tap(tap)
  );

  logic [INS_W-1:0] instr_shift_reg, instr_shift_next;
  logic [INS_W-1:0] instr_reg, instr_next;
  logic [ID_W-1:0] identity_shift_reg, identity_shift_next;
  logic one_bit_skip_reg, one_bit_skip_next;
  logic [CHAIN_W-1:0] pin_chain_reg, pin_chain_next;
  logic [CHAIN_W-1:0] chain_latch_reg, chain_latch_next;
  logic tdo_reg, tdo_next;
  logic tdo_oe_reg, tdo_oe_next;
  logic [GP_N-1:0] gp_o_reg, gp_o_next;
  logic [GP_N-1:0] gp_oe_reg, gp_oe_next;
  logic [GP_N-1:0] gp_sample_reg, gp_sample_next;
  logic extest_reg, extest_next;
  logic tdi_v;
  bst_sel_t sel;
  logic [CHAIN_W-1:0] capture_vec;
  logic [GP_N-1:0] gp_in_v;

  assign tdi_v = filt_reg[SYNC_TDI];
  assign gp_in_v = filt_reg[SYNC_GP +: GP_N];
  assign sel = decode_sel(instr_reg);
  // drive cells see the registered output value; direction cell reads one when tristated
  assign capture_vec = {filt_reg[SYNC_OTHER +: OTHER_W], ~(&gp_oe_reg),
                        gp_interleave(gp_o_reg, gp_in_v)};

  always_comb
  begin
    instr_shift_next = instr_shift_reg;
    instr_next = instr_reg;
    identity_shift_next = identity_shift_reg;
    one_bit_skip_next = one_bit_skip_reg;
    pin_chain_next = pin_chain_reg;
    chain_latch_next = chain_latch_reg;
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_rise)
    begin
      unique case (tap.state)
        ST_CAP_INS: instr_shift_next = INS_CAPTURE;
        ST_SHIFT_INS: instr_shift_next = {tdi_v, instr_shift_reg[INS_W-1:1]};
        ST_CAP_DR:
        begin
          unique case (sel)
            SEL_CHAIN: pin_chain_next = capture_vec;
            SEL_ID: identity_shift_next = ID_VALUE;
            SEL_SKIP: one_bit_skip_next = 1'b0;
          endcase
        end
        ST_SHIFT_DR:
        begin
          unique case (sel)
            SEL_CHAIN: pin_chain_next = {tdi_v, pin_chain_reg[CHAIN_W-1:1]};
            SEL_ID: identity_shift_next = {tdi_v, identity_shift_reg[ID_W-1:1]};
            SEL_SKIP: one_bit_skip_next = tdi_v;
          endcase
        end
        default: ;
      endcase
    end
    if (tck_fall)
    begin
      tdo_oe_next = (tap.state == ST_SHIFT_DR) || (tap.state == ST_SHIFT_INS);
      if (tap.state == ST_SHIFT_INS)
        tdo_next = instr_shift_reg[0];
      else if (tap.state == ST_SHIFT_DR)
      begin
        unique case (sel)
          SEL_CHAIN: tdo_next = pin_chain_reg[0];
          SEL_ID: tdo_next = identity_shift_reg[0];
          SEL_SKIP: tdo_next = one_bit_skip_reg;
        endcase
      end
      if (tap.state == ST_UPD_DR && sel == SEL_CHAIN)
        chain_latch_next = pin_chain_reg;
      if (tap.state == ST_UPD_INS)
        instr_next = instr_shift_reg;
    end
    if (tap.state == ST_RESET)
      instr_next = INS_IDCODE;
  end

  // general pin chain drive applies only under the external test code, else core owns them; other_pins_drive always follows the latch
  always_comb
  begin
    extest_next = (instr_reg == INS_EXTEST) && (tap.state != ST_RESET);
    gp_sample_next = gp_in_v;
    if (extest_reg)
    begin
      gp_o_next = gp_drive_cells(chain_latch_reg);
      gp_oe_next = chain_latch_reg[DIR_CELL] ? '0 : '1;
    end
    else
    begin
      gp_o_next = core_gp_drive;
      gp_oe_next = core_gp_enable;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      instr_shift_reg <= INS_CAPTURE;
      instr_reg <= INS_IDCODE;
      identity_shift_reg <= ID_VALUE;
      one_bit_skip_reg <= 1'b0;
      pin_chain_reg <= CHAIN_RESET;
      chain_latch_reg <= CHAIN_RESET;
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
      gp_o_reg <= '0;
      gp_oe_reg <= '0;
      gp_sample_reg <= '0;
      extest_reg <= 1'b0;
    end
    else
    begin
      instr_shift_reg <= instr_shift_next;
      instr_reg <= instr_next;
      identity_shift_reg <= identity_shift_next;
      one_bit_skip_reg <= one_bit_skip_next;
      pin_chain_reg <= pin_chain_next;
      chain_latch_reg <= chain_latch_next;
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
      gp_o_reg <= gp_o_next;
      gp_oe_reg <= gp_oe_next;
      gp_sample_reg <= gp_sample_next;
      extest_reg <= extest_next;
    end
  end

  assign tdo = tdo_reg;
  assign tdo_oe = tdo_oe_reg;
  assign general_pins_o = gp_o_reg;
  assign general_pins_oe = gp_oe_reg;
  assign core_gp_sample = gp_sample_reg;
  assign other_pins_drive = chain_latch_reg[CHAIN_W-1:OTHER_LO];
  assign test_drive_active = extest_reg;
endmodule

//--- test/bst_top_sva.sv
`timescale 1ns/100ps
module bst_top_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [bst_pkg::GP_N-1:0] general_pins_o,
  input wire logic [bst_pkg::GP_N-1:0] general_pins_oe,
  input wire logic [bst_pkg::GP_N-1:0] core_gp_drive,
  input wire logic [bst_pkg::GP_N-1:0] core_gp_enable,
  input wire logic [bst_pkg::OTHER_W-1:0] other_pins_drive,
  input wire logic test_drive_active
);
  import bst_pkg::*;
  logic tck_reg, tck_next;
  logic [3:0] fall_reg, fall_next;
  logic [2:0] ones_reg, ones_next;
  // cycles since the raw tck pin fell; saturates so an idle link never wraps
  always_comb
  begin
    tck_next = tck;
    fall_next = (tck_reg && !tck) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hf};
    ones_next = ones_reg;
    if (!tck_reg && tck)
      ones_next = tms ? ones_reg + {2'h0, ones_reg != 3'h7} : 3'h0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tck_reg <= 1'b0;
      fall_reg <= 4'hf;
      ones_reg <= 3'h0;
    end
    else
    begin
      tck_reg <= tck_next;
      fall_reg <= fall_next;
      ones_reg <= ones_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_tdo_on_fall: assert property ($changed(tdo) |-> fall_reg <= 4'ha)
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> fall_reg <= 4'ha)
    else $error("tdo enable moved away from a tck fall");
  a_core_path: assert property (!test_drive_active && !$past(test_drive_active) && !$past(rst) |->
    general_pins_o == $past(core_gp_drive) && general_pins_oe == $past(core_gp_enable))
    else $error("general pins left the core path");
  a_dir_uniform: assert property (
    test_drive_active && $past(test_drive_active, 2) |-> general_pins_oe inside {8'h00, 8'hff})
    else $error("general pin enables split under test drive");
  a_latch_on_fall: assert property ($changed(other_pins_drive) |-> fall_reg <= 4'ha)
    else $error("chain latch moved away from a tck fall");
  a_drive_on_fall: assert property (
    test_drive_active && $past(test_drive_active, 2) && $changed(general_pins_o) |-> fall_reg <= 4'ha)
    else $error("test drive moved away from a tck fall");
  a_tms_reset: assert property ($rose(ones_reg == 3'h5) |-> ##[0:12] !test_drive_active && !tdo_oe)
    else $error("five tms highs did not reset the port");
  a_reset_out: assert property ($fell(rst) |-> !tdo_oe && !test_drive_active && general_pins_oe == 8'h00
    && other_pins_drive == '0)
    else $error("outputs not idle after reset");
  c_shift: cover property ($rose(tdo_oe));
  c_extest: cover property ($rose(test_drive_active));
  c_tms_reset: cover property ($rose(ones_reg == 3'h5));
  c_pause: cover property ($fell(tdo_oe) ##[1:60] $rose(tdo_oe));
endmodule
bind bst_top bst_top_chk i_chk (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .general_pins_o(general_pins_o), .general_pins_oe(general_pins_oe), .core_gp_drive(core_gp_drive),
  .core_gp_enable(core_gp_enable), .other_pins_drive(other_pins_drive), .test_drive_active(test_drive_active));

//--- test/bst_tester.sv
`timescale 1ns/100ps
module bst_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tms and tdi move mid-low so the sampler sees them settled around the rise
  task automatic tick(input logic m, input logic d, output logic q);
    #40;
    tms = m;
    tdi = d;
    #40;
    tck = 1'b1;
    // an undriven tdo must never pass as data
    q = tdo_oe ? tdo : 1'bx;
    #80;
    tck = 1'b0;
  endtask
endmodule

//--- test/test_bst_top.sv
`timescale 1ns/100ps
module test_bst_top;
  import bst_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, q, drv_act;
  logic [GP_N-1:0] gp_i, gp_o, gp_oe, c_drv, c_en, c_smp;
  logic [OTHER_W-1:0] oth_i, oth_o;
  logic [31:0] rng = 32'h00004f4e;
  logic [127:0] din, dout, pre;
  logic [2:0] skip[5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
  int fail_count = 0;
  int total_checks = 0;
  bit pause_mid = 1'b0;
  always #5 ref_clk = ~ref_clk;
  bst_top i_dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .general_pins_i(gp_i), .general_pins_o(gp_o), .general_pins_oe(gp_oe), .core_gp_drive(c_drv),
    .core_gp_enable(c_en), .core_gp_sample(c_smp), .other_pins_i(oth_i), .other_pins_drive(oth_o),
    .test_drive_active(drv_act));
  bst_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  function automatic logic [127:0] rnd();
    for (int i = 0; i < 4; i++)
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      rnd = {rnd[95:0], rng};
    end
  endfunction
  function automatic logic [127:0] cap(input logic [GP_N-1:0] drv, input logic [GP_N-1:0] en);
    cap = '0;
    for (int i = 0; i < GP_N; i++)
      cap[2*i +: 2] = {gp_i[i], drv[i]};
    cap[DIR_CELL] = ~&en;
    cap[CHAIN_W-1:OTHER_LO] = oth_i;
  endfunction
  function automatic logic [GP_N-1:0] evn(input logic [127:0] v);
    for (int i = 0; i < GP_N; i++)
      evn[i] = v[2*i];
  endfunction
  // one-stage skip path: a zero from capture, then each bit one period late
  function automatic logic [127:0] skip_model(input logic [127:0] v, input int n);
    logic stage[$];
    skip_model = '0;
    stage.push_back(1'b0);
    for (int k = 0; k < n; k++)
    begin
      stage.push_back(v[k]);
      skip_model[k] = stage.pop_front();
    end
  endfunction
  task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tr(input logic m);
    logic [127:0] r;
    r = rnd();
    i_tester.tick(m, r[0], q);
  endtask
  // starts and ends in idle; n data bits, first bit out sampled on the first shift rise
  task automatic scan(input bit instr, input int n, input logic [127:0] di);
    tr(1'b1);
    if (instr)
      tr(1'b1);
    tr(1'b0);
    tr(1'b0);
    dout = '0;
    for (int k = 0; k < n; k++)
    begin
      i_tester.tick(k == n - 1 || (pause_mid && k == n / 2), di[k], q);
      dout[k] = q;
      // a pause mid-scan must resume on the next bit without losing one
      if (pause_mid && k == n / 2)
      begin
        tr(1'b0);
        tr(1'b1);
        tr(1'b0);
      end
    end
    tr(1'b1);
    tr(1'b0);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    // about 460 test clock periods are needed; allow well over twice that
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    {gp_i, c_drv, c_en, oth_i} = '0;
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    tr(1'b0);
    scan(0, 32, rnd());
    chk("idcode", {96'h0, ID_REV, ID_PART, ID_MAKER, 1'b1}, dout);
    foreach (skip[j])
    begin
      scan(1, 3, {125'h0, skip[j]});
      chk("instr capture", 128'h4, dout);
      din = rnd();
      scan(0, 16, din);
      chk("bypass", skip_model(din, 16), dout);
    end
    din = rnd();
    {gp_i, c_drv, c_en} = din[23:0];
    oth_i = din[127:47];
    scan(1, 3, 128'h4);
    pre = rnd();
    pre[DIR_CELL] = 1'b0;
    scan(0, CHAIN_W, pre);
    chk("sample capture", cap(c_drv, c_en), dout);
    chk("core path", 128'({1'b0, c_en, c_drv, gp_i}), 128'({drv_act, gp_oe, gp_o, c_smp}));
    // preloaded latch reaches the general pins only once the instruction switches; other pins follow it at once
    scan(1, 3, 128'h0);
    chk("extest drive", 128'({1'b1, 8'hff, evn(pre), pre[CHAIN_W-1:OTHER_LO]}),
      128'({drv_act, gp_oe, gp_o, oth_o}));
    din = rnd();
    din[DIR_CELL] = 1'b1;
    scan(0, CHAIN_W, din);
    chk("extest capture", cap(evn(pre), 8'hff), dout);
    chk("extest tristate", 128'({8'h00, evn(din), din[CHAIN_W-1:OTHER_LO]}),
      128'({gp_oe, gp_o, oth_o}));
    repeat (5) tr(1'b1);
    tr(1'b0);
    chk("port reset", 128'({2'h0, c_en, c_drv}), 128'({drv_act, tdo_oe, gp_oe, gp_o}));
    pause_mid = 1'b1;
    scan(0, 32, rnd());
    chk("idcode", {96'h0, ID_REV, ID_PART, ID_MAKER, 1'b1}, dout);
    tally_and_finish();
  end
endmodule
